/* File: design/acc_pkg.sv */
// constants, types and register map of the analog comparator control block
package acc_pkg;

  localparam int NCMP = 3;

  // byte addresses of the register map
  localparam logic [15:0] OFS_CTL [NCMP] = '{16'hA000, 16'hA010, 16'hA020};
  localparam logic [15:0] OFS_STAT       = 16'hA060;
  localparam logic [15:0] OFS_IRQ_STAT   = 16'hA070;
  localparam logic [15:0] OFS_IRQ_MASK   = 16'hA080;

  // bit positions, control register
  localparam int BIT_ON       = 15;
  localparam int BIT_PIN      = 14;
  localparam int BIT_INV      = 13;
  localparam int BIT_LVL      = 8;
  localparam int BIT_EDGE_HI  = 7;
  localparam int BIT_EDGE_LO  = 6;
  localparam int BIT_PLUS     = 4;
  localparam int BIT_MINUS_HI = 1;
  localparam int BIT_MINUS_LO = 0;

  // bit positions, shared status register
  localparam int BIT_IDLE     = 13;

  // reset values and writable masks
  localparam logic [31:0] CTL_RESET  = 32'h0000_E1C3;
  localparam logic [31:0] STAT_RESET = 32'h0000_0000;
  localparam logic [31:0] CTL_WMASK  = 32'h0000_E0D3;
  localparam logic [31:0] STAT_WMASK = 32'h0000_2000;
  localparam logic [31:0] IRQ_WMASK  = 32'h0000_0007;
  localparam logic [2:0]  IRQ_RESET  = 3'h0;
  // bits that may ever read as one
  localparam logic [31:0] RD_MASK    = 32'h0000_E1D7;

  // companion address kind, taken from address bits 3:2
  typedef enum logic [1:0] {
    ACC_WR_PLAIN = 2'h0,
    ACC_WR_CLR   = 2'h1,
    ACC_WR_SET   = 2'h2,
    ACC_WR_INV   = 2'h3
  } acc_alias_t;

  typedef enum logic [1:0] {
    ACC_EDGE_OFF  = 2'h0,
    ACC_EDGE_RISE = 2'h1,
    ACC_EDGE_FALL = 2'h2,
    ACC_EDGE_BOTH = 2'h3
  } acc_edge_t;

  typedef enum logic [1:0] {
    ACC_MINUS_PIN_B   = 2'h0,
    ACC_MINUS_PIN_C   = 2'h1,
    ACC_MINUS_PIN_D   = 2'h2,
    ACC_MINUS_ABS_REF = 2'h3
  } acc_minus_sel_t;

  // control toward one analog comparator core
  typedef struct packed {
    logic           enable;
    logic           plus_ladder;
    acc_minus_sel_t minus_sel;
  } acc_core_ctl_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } acc_bus_req_t;

  typedef struct packed {
    logic [NCMP-1:0] ctl;
    logic            stat;
    logic            istat;
    logic            imask;
    acc_alias_t      kind;
  } acc_dec_t;

endpackage

/* File: design/acc_sync.sv */
// two-flop synchroniser for the asynchronous comparator results
`timescale 1ns/1ps
module acc_sync (
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic [acc_pkg::NCMP-1:0] async_in,
  output logic      [acc_pkg::NCMP-1:0] sync_out
);

  logic [acc_pkg::NCMP-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

/* File: design/acc_top.sv */
// analog comparator control: registers, input routing, polarity and edge events
//
// Function
// RULE_01: enable bit 15 off disables comparator
// RULE_02: bit 14 drives result onto pin
// RULE_03: bit 13 inverts the presented result
// RULE_04: inversion also feeds the edge detector
// RULE_05: bit 8 reads live result level
// RULE_06: bits 7:6 pick interrupt edge
// RULE_07: bit 4 picks ladder or pin A
// RULE_08: bits 1:0 pick minus input source
// RULE_09: idle stop disables all in idle
// RULE_10: status bits 2:0 show three results
// RULE_11: clear, set, invert companions at +4/+8/+C
// RULE_12: reset loads E1C3 and zero status
// RULE_13: unimplemented bits read zero, ignore writes
// RULE_14: software avoids access right after disable
// RULE_15: synchronise results, one-cycle event pulses
`timescale 1ns/1ps
module acc_top (
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire acc_pkg::acc_bus_req_t         bus_req,
  output logic      [31:0]                   bus_rdata,
  input  wire logic                          idle_mode,
  input  wire logic [acc_pkg::NCMP-1:0]      raw_result,
  output acc_pkg::acc_core_ctl_t [acc_pkg::NCMP-1:0] core_ctl,
  output logic      [acc_pkg::NCMP-1:0]      result_output_pin,
  output logic      [acc_pkg::NCMP-1:0]      result_output_pin_oe,
  output logic      [acc_pkg::NCMP-1:0]      irq_event,
  output logic                               irq
);

  localparam int N = acc_pkg::NCMP;

  logic [31:0]        ctl_reg [N];
  logic               idle_stop_reg;
  logic [N-1:0]       level_reg;
  logic [N-1:0]       level_next;
  logic [N-1:0]       event_next;
  logic [N-1:0]       irq_stat_reg;
  logic [N-1:0]       irq_mask_reg;
  logic [N-1:0]       irq_clr;
  logic [N-1:0]       active;
  logic [N-1:0]       sync_q;
  logic [31:0]        rdata_next;
  logic [31:0]        stat_image;
  logic [31:0]        stat_wr;
  logic [2:0]         settle_reg;
  acc_pkg::acc_dec_t  dec;

  // address decode, shared by the write and read paths
  function automatic acc_pkg::acc_dec_t decode(input logic [15:0] a);
    acc_pkg::acc_dec_t d;
    logic [15:0]       base;
    base = {a[15:4], 4'h0};
    d = '0;
    d.kind = acc_pkg::acc_alias_t'(a[3:2]);
    for (int i = 0; i < N; i++) begin
      d.ctl[i] = (base == acc_pkg::OFS_CTL[i]);
    end
    d.stat  = (base == acc_pkg::OFS_STAT);
    // own registers have no companions
    d.istat = (a == acc_pkg::OFS_IRQ_STAT);
    d.imask = (a == acc_pkg::OFS_IRQ_MASK);
    // misaligned byte addresses hit nothing
    if (a[1:0] != 2'h0) begin
      d = '0;
    end
    return d;
  endfunction

  // plain, clear, set or toggle write limited to writable bits
  function automatic logic [31:0] apply_wr(
    input logic [31:0]         old,
    input logic [31:0]         d,
    input acc_pkg::acc_alias_t k,
    input logic [31:0]         m
  );
    logic [31:0] n;
    unique case (k)
      acc_pkg::ACC_WR_PLAIN: n = d;
      acc_pkg::ACC_WR_CLR:   n = old & ~d;
      acc_pkg::ACC_WR_SET:   n = old | d;
      acc_pkg::ACC_WR_INV:   n = old ^ d;
    endcase
    return (old & ~m) | (n & m);
  endfunction

  assign dec = decode(bus_req.addr);

  acc_sync u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (raw_result),
    .sync_out (sync_q)
  );

  // control registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        ctl_reg[i] <= acc_pkg::CTL_RESET; // [RULE_12]
      end
    end else if (bus_req.wr) begin
      for (int i = 0; i < N; i++) begin
        if (dec.ctl[i]) begin
          // only the writable bits change; mask protects the rest [RULE_01] [RULE_11] [RULE_13]
          ctl_reg[i] <= apply_wr(ctl_reg[i], bus_req.wdata, dec.kind,
                                 acc_pkg::CTL_WMASK);
        end
      end
    end
  end

  // shared status register image, only idle stop is stored
  always_comb begin
    stat_image = '0;
    stat_image[acc_pkg::BIT_IDLE] = idle_stop_reg;
  end

  assign stat_wr = apply_wr(stat_image, bus_req.wdata, dec.kind, acc_pkg::STAT_WMASK);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idle_stop_reg <= acc_pkg::STAT_RESET[acc_pkg::BIT_IDLE]; // [RULE_12]
    end else if (bus_req.wr && dec.stat) begin
      idle_stop_reg <= stat_wr[acc_pkg::BIT_IDLE]; // [RULE_11]
    end
  end

  // comparator enable and input routing
  always_comb begin
    for (int i = 0; i < N; i++) begin
      // idle stop overrides every enable while the device idles
      active[i] = ctl_reg[i][acc_pkg::BIT_ON]
                  & ~(idle_stop_reg & idle_mode); // [RULE_01] [RULE_09]
      core_ctl[i].enable      = active[i];
      core_ctl[i].plus_ladder = ctl_reg[i][acc_pkg::BIT_PLUS]; // [RULE_07]
      core_ctl[i].minus_sel   = acc_pkg::acc_minus_sel_t'(
        ctl_reg[i][acc_pkg::BIT_MINUS_HI:acc_pkg::BIT_MINUS_LO]); // [RULE_08]
    end
  end

  // presented level: polarity applied after synchronising
  always_comb begin
    for (int i = 0; i < N; i++) begin
      // a disabled core has no valid result, so hold it low
      level_next[i] = active[i]
                      & (sync_q[i] ^ ctl_reg[i][acc_pkg::BIT_INV]); // [RULE_03] [RULE_15]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      level_reg <= '0;
    end else begin
      level_reg <= level_next;
    end
  end

  // edge qualification on the already inverted level
  always_comb begin
    for (int i = 0; i < N; i++) begin
      unique case (acc_pkg::acc_edge_t'(
                     ctl_reg[i][acc_pkg::BIT_EDGE_HI:acc_pkg::BIT_EDGE_LO]))
        acc_pkg::ACC_EDGE_OFF:  event_next[i] = 1'b0;
        acc_pkg::ACC_EDGE_RISE: event_next[i] = level_next[i] & ~level_reg[i];
        acc_pkg::ACC_EDGE_FALL: event_next[i] = ~level_next[i] & level_reg[i];
        acc_pkg::ACC_EDGE_BOTH: event_next[i] = level_next[i] ^ level_reg[i];
      endcase // [RULE_04] [RULE_06]
    end
  end

  // events held off until synchroniser and level register carry real data;
  // limitation: a true edge in the first three cycles after reset is lost
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      settle_reg <= '0;
    end else begin
      settle_reg <= {settle_reg[1:0], 1'b1};
    end
  end

  // one pulse per qualifying edge toward the interrupt controller
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_event <= '0;
    end else begin
      irq_event <= event_next & {N{settle_reg[2]}}; // [RULE_15]
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  assign irq_clr = (bus_req.wr && dec.istat) ? bus_req.wdata[N-1:0] : '0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= acc_pkg::IRQ_RESET;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_event;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_reg <= acc_pkg::IRQ_RESET;
    end else if (bus_req.wr && dec.imask) begin
      irq_mask_reg <= bus_req.wdata[N-1:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // output pins
  always_comb begin
    for (int i = 0; i < N; i++) begin
      result_output_pin_oe[i] = ctl_reg[i][acc_pkg::BIT_PIN]; // [RULE_02]
    end
  end

  assign result_output_pin = level_reg;

  // read mux; companion addresses read as zero
  always_comb begin
    rdata_next = '0;
    if (dec.kind == acc_pkg::ACC_WR_PLAIN) begin
      for (int i = 0; i < N; i++) begin
        if (dec.ctl[i]) begin
          rdata_next = ctl_reg[i] & acc_pkg::CTL_WMASK; // [RULE_13]
          rdata_next[acc_pkg::BIT_LVL] = level_reg[i]; // [RULE_05]
        end
      end
      if (dec.stat) begin
        rdata_next[acc_pkg::BIT_IDLE] = idle_stop_reg;
        rdata_next[N-1:0] = level_reg; // [RULE_10]
      end
    end
    if (dec.istat) begin
      rdata_next[N-1:0] = irq_stat_reg;
    end
    if (dec.imask) begin
      rdata_next[N-1:0] = irq_mask_reg;
    end
  end

  // data valid only in the cycle after the read strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= '0;
    end else if (bus_req.rd) begin
      bus_rdata <= rdata_next;
    end else begin
      bus_rdata <= '0;
    end
  end

  // checks per comparator
  for (genvar g = 0; g < N; g++) begin : g_chk

    a_disable_low : assert property (@(posedge mclk) disable iff (!rst_n)
      !ctl_reg[g][acc_pkg::BIT_ON] && !$past(ctl_reg[g][acc_pkg::BIT_ON])
      |=> !level_reg[g] && !irq_event[g])
      else $error("disabled comparator shows a level"); // [RULE_01]

    a_on_clear_keeps : assert property (@(posedge mclk) disable iff (!rst_n)
      bus_req.wr && dec.ctl[g] && dec.kind == acc_pkg::ACC_WR_CLR
      && bus_req.wdata == 32'h0000_8000
      |=> !ctl_reg[g][acc_pkg::BIT_ON]
          && ctl_reg[g][14:0] == $past(ctl_reg[g][14:0]))
      else $error("enable clear disturbed other bits"); // [RULE_01]

    a_pin_drive : assert property (@(posedge mclk) disable iff (!rst_n)
      bus_req.wr && dec.ctl[g] && dec.kind == acc_pkg::ACC_WR_PLAIN
      |=> result_output_pin_oe[g] == $past(bus_req.wdata[acc_pkg::BIT_PIN])
          && result_output_pin[g] == level_reg[g])
      else $error("pin drive does not follow its enable"); // [RULE_02]

    a_invert_path : assert property (@(posedge mclk) disable iff (!rst_n)
      active[g] |=> level_reg[g]
        == ($past(sync_q[g]) ^ $past(ctl_reg[g][acc_pkg::BIT_INV])))
      else $error("presented level has wrong polarity"); // [RULE_03]

    a_inverted_edge : assert property (@(posedge mclk) disable iff (!rst_n)
      active[g] && $past(active[g]) && $stable(ctl_reg[g])
      && ctl_reg[g][acc_pkg::BIT_INV]
      && ctl_reg[g][7:6] == acc_pkg::ACC_EDGE_RISE && $fell(sync_q[g])
      |=> irq_event[g])
      else $error("inverted falling edge gave no event"); // [RULE_04]

    a_level_read : assert property (@(posedge mclk) disable iff (!rst_n)
      bus_req.rd && dec.ctl[g] && dec.kind == acc_pkg::ACC_WR_PLAIN
      |=> bus_rdata[acc_pkg::BIT_LVL] == $past(level_reg[g]))
      else $error("level bit does not read the live result"); // [RULE_05]

    a_edge_off : assert property (@(posedge mclk) disable iff (!rst_n)
      ctl_reg[g][7:6] == acc_pkg::ACC_EDGE_OFF |=> !irq_event[g])
      else $error("event while edge select is off"); // [RULE_06]

    a_edge_fall : assert property (@(posedge mclk) disable iff (!rst_n)
      ctl_reg[g][7:6] == acc_pkg::ACC_EDGE_FALL && level_reg[g] && settle_reg[2]
      && !level_next[g] |=> irq_event[g] && !level_reg[g])
      else $error("falling edge missed"); // [RULE_06]

    a_minus_set : assert property (@(posedge mclk) disable iff (!rst_n)
      bus_req.wr && dec.ctl[g] && dec.kind == acc_pkg::ACC_WR_SET
      && bus_req.wdata == 32'h0000_0013
      |=> core_ctl[g].minus_sel == acc_pkg::ACC_MINUS_ABS_REF
          && core_ctl[g].plus_ladder)
      else $error("input selection not routed"); // [RULE_07] [RULE_08]

    a_alias_toggle : assert property (@(posedge mclk) disable iff (!rst_n)
      bus_req.wr && dec.ctl[g] && dec.kind == acc_pkg::ACC_WR_INV
      |=> ctl_reg[g] == ($past(ctl_reg[g])
          ^ ($past(bus_req.wdata) & acc_pkg::CTL_WMASK)))
      else $error("toggle companion wrote wrong value"); // [RULE_11]

    a_event_pulse : assert property (@(posedge mclk) disable iff (!rst_n)
      irq_event[g] |-> level_reg[g] != $past(level_reg[g])
        ##1 irq_stat_reg[g])
      else $error("event without a level change"); // [RULE_15]

  end

  a_idle_stop : assert property (@(posedge mclk) disable iff (!rst_n)
    idle_stop_reg && idle_mode |-> active == '0 ##1 level_reg == '0)
    else $error("comparator ran during idle stop"); // [RULE_09]

  a_status_levels : assert property (@(posedge mclk) disable iff (!rst_n)
    bus_req.rd && dec.stat && dec.kind == acc_pkg::ACC_WR_PLAIN
    |=> bus_rdata[N-1:0] == $past(level_reg)
        && bus_rdata[acc_pkg::BIT_IDLE] == $past(idle_stop_reg))
    else $error("status register misreports"); // [RULE_10]

  a_unimpl_zero : assert property (@(posedge mclk) disable iff (!rst_n)
    bus_req.rd |=> (bus_rdata & ~acc_pkg::RD_MASK) == 32'h0000_0000)
    else $error("unimplemented bit read as one"); // [RULE_13]

endmodule

/* File: bench/acc_core_model.sv */
// behavioural model of the three analog comparator cores and their sources
`timescale 1ns/1ps
module acc_core_model (
  input  wire logic                                       mclk,
  input  wire acc_pkg::acc_core_ctl_t [acc_pkg::NCMP-1:0] core_ctl,
  input  wire logic [acc_pkg::NCMP-1:0][5:0][7:0]         src_volt,
  output logic      [acc_pkg::NCMP-1:0]                   raw_result
);
  // sources per core: 0 pin a, 1 ladder, 2..4 pins b..d, 5 absolute reference
  logic [acc_pkg::NCMP-1:0] off_pattern = '0;

  // a powered-down core has no steady result, so it shows a changing pattern
  always @(posedge mclk) off_pattern <= ~off_pattern;

  function automatic logic compare(input acc_pkg::acc_core_ctl_t c, input logic [5:0][7:0] v);
    logic [7:0] plus_v;
    plus_v = c.plus_ladder ? v[1] : v[0];
    return plus_v > v[3'(c.minus_sel) + 3'h2];
  endfunction

  always_comb begin
    for (int i = 0; i < acc_pkg::NCMP; i++) begin
      raw_result[i] = core_ctl[i].enable ? compare(core_ctl[i], src_volt[i])
                                         : off_pattern[i];
    end
  end
endmodule

/* File: bench/tb_top.sv */
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] C1 = 16'hA000;
  localparam logic [15:0] C2 = 16'hA010;
  localparam logic [15:0] C3 = 16'hA020;
  localparam logic [15:0] ST = 16'hA060;
  localparam logic [15:0] IS = 16'hA070;
  localparam logic [15:0] IM = 16'hA080;
  // expected result per plus/minus choice with the source levels set below
  localparam logic [7:0]  SWEEP_LVL = 8'h45;

  logic                                       mclk = 1'b0;
  logic                                       rst_n = 1'b0;
  acc_pkg::acc_bus_req_t                      bus_req = '0;
  logic                                       idle_mode = 1'b0;
  logic [acc_pkg::NCMP-1:0][5:0][7:0]         src_volt;
  logic [31:0]                                bus_rdata;
  logic [acc_pkg::NCMP-1:0]                   raw_result;
  logic [acc_pkg::NCMP-1:0]                   pin;
  logic [acc_pkg::NCMP-1:0]                   pin_oe;
  logic [acc_pkg::NCMP-1:0]                   irq_event;
  acc_pkg::acc_core_ctl_t [acc_pkg::NCMP-1:0] core_ctl;
  logic                                       irq;
  int                                         fail_count = 0;
  int                                         check_count = 0;
  int                                         ev_count = 0;

  always #2.5 mclk = ~mclk;

  acc_top acc_top_inst (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .idle_mode(idle_mode), .raw_result(raw_result), .core_ctl(core_ctl),
    .result_output_pin(pin), .result_output_pin_oe(pin_oe), .irq_event(irq_event), .irq(irq));

  acc_core_model acc_core_model_inst (.mclk(mclk), .core_ctl(core_ctl), .src_volt(src_volt),
    .raw_result(raw_result));

  always @(posedge mclk) if (irq_event[0] === 1'b1) ev_count <= ev_count + 1;

  task automatic give_verdict();
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    check("read data", bus_rdata, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic set_idle(input logic v);
    @(posedge mclk);
    idle_mode <= v;
    tick(4);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    give_verdict();
  end

  initial begin
    int base;
    logic fire;
    logic [31:0] v;
    for (int i = 0; i < 3; i++) src_volt[i] = {8'hC8, 8'h0A, 8'h96, 8'h32, 8'h14, 8'h64};
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    tick(6);
    check("pin enables", 32'(pin_oe), 32'h0000_0007);
    rd(C1, 32'h0000_E1C3);
    rd(C2, 32'h0000_E1C3);
    rd(C3, 32'h0000_E1C3);
    rd(ST, 32'h0000_0007);
    rd(IS, 32'h0000_0000);
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        v = 32'h0000_8000 | (32'(p) << 4) | 32'(m);
        wr(C3, v);
        tick(4);
        check("core select", 32'(core_ctl[2]), 32'h0000_0008 | (32'(p) << 2) | 32'(m));
        rd(C3, v | (32'(SWEEP_LVL[p * 4 + m]) << 8));
      end
    end
    wr(C3, 32'h0000_E1C3);
    wr(C2 + 16'h0004, 32'h0000_4000);
    rd(C2, 32'h0000_A1C3);
    wr(C2 + 16'h0008, 32'h0000_0010);
    wr(C2 + 16'h000C, 32'h0000_0001);
    tick(4);
    rd(C2, 32'h0000_A0D2);
    rd(C2 + 16'h0004, 32'h0000_0000);
    wr(C2 + 16'h0004, 32'h0000_8000);
    // no access in the cycle right after a disable
    tick(1);
    check("core enable", 32'(core_ctl[1]), 32'h0000_0006);
    tick(3);
    rd(C2, 32'h0000_20D2);
    wr(C2, 32'h0000_E1C3);
    wr(C1, 32'h0000_C000);
    tick(4);
    check("pin", 32'({pin_oe[0], pin[0]}), 32'h0000_0003);
    rd(C1, 32'h0000_C100);
    rd(ST, 32'h0000_0007);
    wr(C1, 32'h0000_E000);
    tick(4);
    check("pin", 32'({pin_oe[0], pin[0]}), 32'h0000_0002);
    rd(ST, 32'h0000_0006);
    wr(C1, 32'h0000_A000);
    tick(4);
    check("pin", 32'({pin_oe[0], pin[0]}), 32'h0000_0000);
    wr(ST + 16'h0008, 32'h0000_2000);
    set_idle(1'b1);
    check("enables", 32'({core_ctl[2].enable, core_ctl[1].enable, core_ctl[0].enable}), 0);
    rd(ST, 32'h0000_2000);
    set_idle(1'b0);
    rd(ST, 32'h0000_2006);
    wr(ST + 16'h0004, 32'h0000_2000);
    set_idle(1'b1);
    check("enables", 32'({core_ctl[2].enable, core_ctl[1].enable, core_ctl[0].enable}), 7);
    set_idle(1'b0);
    for (int e = 0; e < 4; e++) begin
      for (int inv = 0; inv < 2; inv++) begin
        wr(C1, 32'h0000_8000 | (32'(inv) << acc_pkg::BIT_INV) | (32'(e) << acc_pkg::BIT_EDGE_LO));
        tick(6);
        wr(IS, 32'h0000_0007);
        for (int rise = 0; rise < 2; rise++) begin
          base = ev_count;
          @(posedge mclk);
          src_volt[0][0] <= (rise == 1) ? 8'h64 : 8'h1E;
          tick(6);
          fire = (e == 3) || (e == 1 && rise != inv) || (e == 2 && rise == inv);
          check("event count", 32'(ev_count - base), 32'(fire));
        end
      end
    end
    wr(IM, 32'h0000_0001);
    check("irq", 32'(irq), 32'h0000_0001);
    rd(IS, 32'h0000_0001);
    wr(IM, 32'h0000_0000);
    check("irq", 32'(irq), 32'h0000_0000);
    wr(IM, 32'h0000_0001);
    wr(IS, 32'h0000_0001);
    check("irq", 32'(irq), 32'h0000_0000);
    rd(IS, 32'h0000_0000);
    wr(16'hA030, 32'hFFFF_FFFF);
    rd(16'hA030, 32'h0000_0000);
    wr(C1, 32'hFFFF_FFFF);
    tick(4);
    rd(C1, 32'h0000_E1D3);
    wr(C3 + 16'h0008, 32'h0000_0013);
    check("core select", 32'(core_ctl[2]), 32'h0000_000F);
    wr(ST, 32'hFFFF_FFFF);
    rd(ST, 32'h0000_2007);
    check("pins", 32'({pin_oe, pin}), 32'h0000_003F);
    check("events", 32'(irq_event), 32'h0000_0000);
    give_verdict();
  end
endmodule
